// ==== rtl/vtp_pkg.sv ====
/*
  Shared constants for the rail A / rail B tracking and phase controller.
  Assumes a single 20 MHz clock domain; all numbers used by the controller live here.
*/
package vtp_pkg;
  // ************************************************************
  // Encodings
  // ************************************************************
  localparam logic [1:0] MODE_OFF       = 2'h0;
  localparam logic [1:0] MODE_PWM       = 2'h1;
  localparam logic [1:0] MODE_PFM       = 2'h2;
  localparam logic [1:0] MODE_AUTO      = 2'h3;
  localparam logic [1:0] PHASE_SINGLE   = 2'h0;
  localparam logic [1:0] PHASE_DUAL     = 2'h1;
  localparam logic [7:0] CODE_MIN       = 8'h00;
  localparam logic [7:0] CODE_MAX_DVS   = 8'hb0;
  localparam logic [7:0] CODE_ZERO      = 8'h00;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int PFM_PWM_MIN_US  = 30;
  localparam int PFM_PWM_CYCLES  = (PFM_PWM_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int RAMP_STEP_CYC   = 4;
  localparam int SYNC_STAGES     = 3;
  typedef enum logic [2:0] {VTP_OFF, VTP_RAMP, VTP_TRACK, VTP_FOLLOW, VTP_HIZ, VTP_PULL} vtp_b_state_e;
endpackage : vtp_pkg

// ==== rtl/vtp_sync.sv ====
/*
  Three-flop input synchroniser with agreement filter.
  Assumes the input is asynchronous to clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module vtp_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      q_out <= '0;
    end
    else
    begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      // Change accepted only when stages two and three agree
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == s3[i])
        begin
          q_out[i] <= s3[i];
        end
      end
    end
  end
endmodule : vtp_sync
`default_nettype wire

// ==== rtl/vtp_ctrl.sv ====
/*
  Rail A / rail B control: tracking mode, enable sequencing, off-state pulldowns,
  mode transition timing and single/dual phase selection.
  Assumes enables and codes come from a register file on mclk_in; the two enable
  pins and standby pin are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Track enable set: rail B reference is rail A feedback halved.
// - In tracking, rail B voltage scaling blocked; target is rail A over two.
// - Rail B starts in the same slot as rail A or a later one.
// - Same slot start: rail B follows half rail A from the start.
// - Later start: ramp to default code, then switch to tracking.
// - Rail A disabled: rail B follows down, both pulldowns on.
// - Rail A re-enabled: ramps to setpoint, rail B stays at half.
// - Only rail B off: select bit picks high impedance or pulldown.
// - Rail B re-enabled: ramp to run/standby code, then track rail A (code ramps to default code instead when same slot is clear).
// - Dual phase: combined rail uses rail A settings only.
// - Phase field 00 single, 01 dual, 10 and 11 reserved.
// - Pulse-frequency to pulse-width change takes at least 30 us.
// - Mode field: 00 off, 01 PWM, 10 PFM, 11 auto skip.
// - Separate eight-bit run and standby codes, 0 to 176 valid for scaling; the code passes any 8-bit code and does not limit it to CODE_MAX_DVS.
module vtp_ctrl
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       rail_a_enable_in,
  input  wire logic       rail_b_enable_in,
  input  wire logic       standby_in,
  input  wire logic       track_mode_enable_in,
  input  wire logic       track_off_pulldown_select_in,
  input  wire logic       rail_b_same_slot_in,
  input  wire logic [1:0] phase_config_select_in,
  input  wire logic [1:0] rail_a_mode_in,
  input  wire logic [1:0] rail_b_mode_in,
  input  wire logic [7:0] rail_a_run_voltage_code_in,
  input  wire logic [7:0] rail_a_standby_voltage_code_in,
  input  wire logic [7:0] rail_b_run_voltage_code_in,
  input  wire logic [7:0] rail_b_standby_voltage_code_in,
  input  wire logic [7:0] rail_b_default_voltage_code_in,
  output var  logic [7:0] rail_a_target_code_out,
  output var  logic [7:0] rail_b_target_code_out,
  output var  logic       rail_b_track_ref_out,
  output var  logic       rail_b_dvs_block_out,
  output var  logic       rail_a_pulldown_out,
  output var  logic       rail_b_pulldown_out,
  output var  logic       rail_b_hiz_out,
  output var  logic [1:0] rail_a_mode_out,
  output var  logic [1:0] rail_b_mode_out,
  output var  logic       dual_phase_out,
  output var  logic       phase_reserved_out
);
  // ************************************************************
  // Input synchronisation
  // ************************************************************
  logic [2:0] pins;
  logic       a_en;
  logic       b_en;
  logic       stby;
  vtp_sync #(.W(3)) u_sync
  (
    .clk_in    (mclk_in),
    .resetn_in (resetn_in),
    .d_in      ({standby_in, rail_b_enable_in, rail_a_enable_in}),
    .q_out     (pins)
  );
  assign a_en = pins[0];
  assign b_en = pins[1];
  assign stby = pins[2];

  function automatic logic [7:0] sel_code(input logic s, input logic [7:0] run, input logic [7:0] sb);
    sel_code = s ? sb : run;
  endfunction : sel_code

  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt)
      step_to = cur + 8'h01;
    else if (cur > tgt)
      step_to = cur - 8'h01;
    else
      step_to = cur;
  endfunction : step_to

  logic               dual;
  logic [7:0]         a_set;
  logic [7:0]         b_set;
  logic [7:0]         a_half;
  logic [3:0]         step_cnt;
  logic               step;
  logic               b_ever_on; // Power-up start and a later re-enable need different ramps
  vtp_pkg::vtp_b_state_e b_st;

  assign dual   = (phase_config_select_in == vtp_pkg::PHASE_DUAL);
  assign a_set  = sel_code(stby, rail_a_run_voltage_code_in, rail_a_standby_voltage_code_in);
  assign b_set  = sel_code(stby, rail_b_run_voltage_code_in, rail_b_standby_voltage_code_in);
  assign a_half = {1'b0, rail_a_target_code_out[7:1]};
  assign step   = (step_cnt == 4'(vtp_pkg::RAMP_STEP_CYC - 1));

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      step_cnt <= 4'h0;
    else
      step_cnt <= step ? 4'h0 : step_cnt + 4'h1;
  end

  // ************************************************************
  // Phase configuration
  // ************************************************************
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dual_phase_out     <= 1'b0;
      phase_reserved_out <= 1'b0;
    end
    else
    begin
      dual_phase_out     <= dual;
      phase_reserved_out <= phase_config_select_in[1];
    end
  end

  // ************************************************************
  // Rail A ramp: off discharges, on ramps to setpoint
  // ************************************************************
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rail_a_target_code_out <= vtp_pkg::CODE_ZERO;
      rail_a_pulldown_out    <= 1'b0;
    end
    else
    begin
      if (step)
        rail_a_target_code_out <= step_to(rail_a_target_code_out, a_en ? a_set : vtp_pkg::CODE_ZERO);
      rail_a_pulldown_out <= !a_en;
    end
  end

  // ************************************************************
  // Rail B sequencing
  // ************************************************************
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      b_st                   <= vtp_pkg::VTP_OFF;
      rail_b_target_code_out <= vtp_pkg::CODE_ZERO;
      b_ever_on              <= 1'b0;
    end
    else
    begin
      case (b_st)
        vtp_pkg::VTP_OFF:
        begin
          rail_b_target_code_out <= vtp_pkg::CODE_ZERO;
          if (dual)
            b_st <= vtp_pkg::VTP_OFF;
          else if (b_en && track_mode_enable_in && rail_b_same_slot_in && a_en && !b_ever_on)
            b_st <= vtp_pkg::VTP_TRACK;
          else if (b_en)
            b_st <= vtp_pkg::VTP_RAMP;
        end
        vtp_pkg::VTP_RAMP:
        begin
          if (!b_en || dual)
            b_st <= vtp_pkg::VTP_OFF;
          else if (!track_mode_enable_in)
          begin
            if (step)
              rail_b_target_code_out <= step_to(rail_b_target_code_out, b_set);
          end
          else if (rail_b_target_code_out == (rail_b_same_slot_in ? b_set : rail_b_default_voltage_code_in))
            b_st <= vtp_pkg::VTP_TRACK;
          else if (step)
            rail_b_target_code_out <= step_to(rail_b_target_code_out,
                                              rail_b_same_slot_in ? b_set : rail_b_default_voltage_code_in);
        end
        vtp_pkg::VTP_TRACK:
        begin
          rail_b_target_code_out <= a_half;
          b_ever_on              <= 1'b1;
          if (!track_mode_enable_in)
            b_st <= vtp_pkg::VTP_RAMP;
          if (!b_en || dual)
            b_st <= vtp_pkg::VTP_OFF;
        end
        default:
          b_st <= vtp_pkg::VTP_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rail_b_track_ref_out <= 1'b0;
      rail_b_dvs_block_out <= 1'b0;
      rail_b_pulldown_out  <= 1'b0;
      rail_b_hiz_out       <= 1'b1;
    end
    else
    begin
      rail_b_track_ref_out <= (b_st == vtp_pkg::VTP_TRACK);
      rail_b_dvs_block_out <= (b_st == vtp_pkg::VTP_TRACK);
      rail_b_pulldown_out  <= ((b_st == vtp_pkg::VTP_OFF) && track_off_pulldown_select_in) ||
                              (!a_en && (b_st != vtp_pkg::VTP_RAMP));
      rail_b_hiz_out       <= (b_st == vtp_pkg::VTP_OFF) && !track_off_pulldown_select_in && a_en;
    end
  end

  // ************************************************************
  // Operating mode with PFM to PWM hold-off
  // ************************************************************
  logic [9:0] pwm_wait [2];
  logic [1:0] mode_req [2];
  logic [1:0] mode_cur [2];
  assign mode_req[0] = rail_a_mode_in;
  assign mode_req[1] = dual ? rail_a_mode_in : rail_b_mode_in;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_mode
      // The pwm_wait hold-off counter hides the PFM settle time from the host
      always_ff @(posedge mclk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          mode_cur[g] <= vtp_pkg::MODE_OFF;
          pwm_wait[g] <= 10'h000;
        end
        else if (pwm_wait[g] != 10'h000)
        begin
          pwm_wait[g] <= pwm_wait[g] - 10'h001;
          if (pwm_wait[g] == 10'h001)
            mode_cur[g] <= vtp_pkg::MODE_PWM;
        end
        else if (mode_cur[g] == vtp_pkg::MODE_PFM && mode_req[g] == vtp_pkg::MODE_PWM)
          pwm_wait[g] <= 10'(vtp_pkg::PFM_PWM_CYCLES);
        else
          mode_cur[g] <= mode_req[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rail_a_mode_out <= vtp_pkg::MODE_OFF;
      rail_b_mode_out <= vtp_pkg::MODE_OFF;
    end
    else
    begin
      rail_a_mode_out <= mode_cur[0];
      rail_b_mode_out <= mode_cur[1];
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  track_ref_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    b_st == vtp_pkg::VTP_TRACK |=> rail_b_target_code_out == $past(a_half)) else $error("track target wrong");
  dvs_block_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    b_st == vtp_pkg::VTP_TRACK |=> rail_b_dvs_block_out) else $error("dvs not blocked");
  same_slot_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    b_st == vtp_pkg::VTP_OFF && b_en && track_mode_enable_in && rail_b_same_slot_in && a_en && !dual && !b_ever_on
    |=> b_st == vtp_pkg::VTP_TRACK) else $error("same slot no track");
  late_slot_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    $rose(b_st == vtp_pkg::VTP_TRACK) && !rail_b_same_slot_in && $past(b_st) == vtp_pkg::VTP_RAMP
    |-> $past(rail_b_target_code_out) == $past(rail_b_default_voltage_code_in)) else $error("early track");
  a_off_pull_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !a_en |=> rail_a_pulldown_out) else $error("rail a pulldown off");
  b_off_hiz_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    b_st == vtp_pkg::VTP_OFF && a_en |=> rail_b_hiz_out == !$past(track_off_pulldown_select_in))
    else $error("rail b off state wrong");
  phase_sel_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    1'b1 |=> dual_phase_out == ($past(phase_config_select_in) == vtp_pkg::PHASE_DUAL)) else $error("phase wrong");
  pfm_pwm_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    mode_cur[0] == vtp_pkg::MODE_PFM && rail_a_mode_in == vtp_pkg::MODE_PWM && pwm_wait[0] == 10'h000
    |=> mode_cur[0] == vtp_pkg::MODE_PFM [*8]) else $error("pwm too early");
  dual_b_off_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    dual |=> ##1 b_st == vtp_pkg::VTP_OFF) else $error("rail b active in dual");
  indep_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !track_mode_enable_in |=> ##1 !rail_b_track_ref_out) else $error("tracking while disabled");
  cov_track_c: cover property (@(posedge mclk_in) b_st == vtp_pkg::VTP_TRACK);
  cov_late_c: cover property (@(posedge mclk_in) b_st == vtp_pkg::VTP_RAMP ##1 b_st == vtp_pkg::VTP_TRACK);
  cov_aoff_c: cover property (@(posedge mclk_in) b_st == vtp_pkg::VTP_TRACK && !a_en);
  cov_pwm_c: cover property (@(posedge mclk_in) pwm_wait[0] == 10'h001);
endmodule : vtp_ctrl
`default_nettype wire

// ==== verif/vtp_host_model.sv ====
/*
  Host model: the voltage codes that a controlling processor would program.
  Assumes the bench changes its requests at the falling edge of the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module vtp_host_model
(
  input  wire logic       track_in,
  input  wire logic [7:0] a_run_req_in,
  input  wire logic [7:0] a_stby_req_in,
  input  wire logic [7:0] b_own_in,
  output var  logic [7:0] a_run_out,
  output var  logic [7:0] a_stby_out,
  output var  logic [7:0] b_run_out,
  output var  logic [7:0] b_stby_out
);
  // ************************************************************
  // Code programming
  // ************************************************************
  // Below 800 mV on rail A the tracking rail would leave its range
  always_comb
  begin
    a_run_out  = (track_in && a_run_req_in < 8'h40) ? 8'h40 : a_run_req_in;
    a_stby_out = (track_in && a_stby_req_in < 8'h40) ? 8'h40 : a_stby_req_in;
    b_run_out  = track_in ? a_run_out >> 1 : b_own_in;
    b_stby_out = track_in ? a_stby_out >> 1 : b_own_in;
  end
endmodule : vtp_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
  Self-checking bench for vtp_ctrl, with the host model supplying voltage codes.
  Assumes a 20 MHz clock; all inputs change at the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] ph; logic [1:0] md; logic dl; logic rs;} vtp_row_s;
  logic       mclk_in = 1'b0, resetn_in = 1'b0;
  logic       a_en = 1'b0, b_en = 1'b0, stby = 1'b0, track = 1'b0, pd_sel = 1'b0, same = 1'b1;
  logic [1:0] phase = 2'h0, a_mode = 2'h3, b_mode = 2'h3, a_mode_o, b_mode_o;
  logic [7:0] a_req = 8'h50, a_sreq = 8'h48, b_own = 8'h20, b_def = 8'h10;
  logic [7:0] a_run, a_stby, b_run, b_stby, a_tgt, b_tgt, prev_a;
  logic       b_ref, b_blk, a_pd, b_pd, b_hiz, dual, resv;
  int         failures = 0, n_compared = 0, cycles = 0;
  vtp_row_s   rows [4] = '{'{2'h0, 2'h0, 1'b0, 1'b0}, '{2'h1, 2'h1, 1'b1, 1'b0},
                           '{2'h2, 2'h2, 1'b0, 1'b1}, '{2'h3, 2'h3, 1'b0, 1'b1}};
  vtp_host_model hm (.track_in(track), .a_run_req_in(a_req), .a_stby_req_in(a_sreq), .b_own_in(b_own),
                     .a_run_out(a_run), .a_stby_out(a_stby), .b_run_out(b_run), .b_stby_out(b_stby));
  vtp_ctrl uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .rail_a_enable_in(a_en), .rail_b_enable_in(b_en),
    .standby_in(stby), .track_mode_enable_in(track), .track_off_pulldown_select_in(pd_sel),
    .rail_b_same_slot_in(same), .phase_config_select_in(phase), .rail_a_mode_in(a_mode),
    .rail_b_mode_in(b_mode), .rail_a_run_voltage_code_in(a_run), .rail_a_standby_voltage_code_in(a_stby),
    .rail_b_run_voltage_code_in(b_run), .rail_b_standby_voltage_code_in(b_stby),
    .rail_b_default_voltage_code_in(b_def), .rail_a_target_code_out(a_tgt), .rail_b_target_code_out(b_tgt),
    .rail_b_track_ref_out(b_ref), .rail_b_dvs_block_out(b_blk), .rail_a_pulldown_out(a_pd),
    .rail_b_pulldown_out(b_pd), .rail_b_hiz_out(b_hiz), .rail_a_mode_out(a_mode_o),
    .rail_b_mode_out(b_mode_o), .dual_phase_out(dual), .phase_reserved_out(resv));
  // ************************************************************
  // Clock, timeout and helpers
  // ************************************************************
  initial
  begin
    forever #25 mclk_in = ~mclk_in;
  end
  // About 2500 cycles expected; the ceiling leaves ample margin
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : cyc
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    resetn_in = 1'b0;
    cyc(10);
    resetn_in = 1'b1;
  endtask : do_reset
  task automatic wait_code(input logic sel_b, input logic [7:0] code);
    int n;
    for (n = 0; n < 2000 && (sel_b ? b_tgt : a_tgt) !== code; n++)
      cyc(1);
    chk("target code", code, sel_b ? b_tgt : a_tgt);
  endtask : wait_code
  // Rail B lags rail A by one register, so compare only once rail A has held a cycle
  task automatic ramp_track(input logic [7:0] code);
    int n;
    for (n = 0; n < 2000 && a_tgt !== code; n++)
    begin
      prev_a = a_tgt;
      cyc(1);
      if (a_tgt === prev_a)
        chk("rail b half", a_tgt >> 1, b_tgt);
    end
    chk("rail a final", code, a_tgt);
  endtask : ramp_track
  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    cyc(10);
    chk("reset hiz", 8'h01, {7'h00, b_hiz});
    chk("reset pulldown", 8'h00, {7'h00, b_pd});
    chk("reset code", 8'h00, a_tgt);
    $display("Test reset done");
    resetn_in = 1'b1;
    a_en = 1'b1;
    foreach (rows[i])
    begin
      phase = rows[i].ph;
      a_mode = rows[i].md;
      cyc(8);
      chk("dual", {7'h00, rows[i].dl}, {7'h00, dual});
      chk("reserved", {7'h00, rows[i].rs}, {7'h00, resv});
      chk("mode", {6'h00, rows[i].md}, {6'h00, a_mode_o});
      chk("b mode", rows[i].dl ? {6'h00, rows[i].md} : {6'h00, b_mode}, {6'h00, b_mode_o});
    end
    $display("Test phase and mode table done");
    phase = 2'h0;
    a_mode = 2'h1;
    b_en = 1'b1;
    track = 1'b1;
    do_reset();
    ramp_track(8'h50);
    cyc(2);
    chk("track ref", 8'h01, {7'h00, b_ref});
    chk("dvs block", 8'h01, {7'h00, b_blk});
    chk("rail b", 8'h28, b_tgt);
    a_en = 1'b0;
    ramp_track(8'h00);
    cyc(2);
    chk("a pulldown", 8'h01, {7'h00, a_pd});
    chk("b pulldown", 8'h01, {7'h00, b_pd});
    a_en = 1'b1;
    ramp_track(8'h50);
    stby = 1'b1;
    ramp_track(8'h48);
    stby = 1'b0;
    ramp_track(8'h50);
    $display("Test same slot tracking done");
    b_en = 1'b0;
    cyc(12);
    chk("b hiz", 8'h01, {7'h00, b_hiz});
    chk("b pulldown off", 8'h00, {7'h00, b_pd});
    pd_sel = 1'b1;
    cyc(4);
    chk("b pulldown on", 8'h01, {7'h00, b_pd});
    chk("b hiz off", 8'h00, {7'h00, b_hiz});
    b_en = 1'b1;
    cyc(20);
    chk("ref during ramp", 8'h00, {7'h00, b_ref});
    wait_code(1'b1, b_run);
    cyc(3);
    chk("ref after ramp", 8'h01, {7'h00, b_ref});
    $display("Test rail b off and on done");
    a_mode = 2'h2;
    cyc(8);
    a_mode = 2'h1;
    cyc(vtp_pkg::PFM_PWM_CYCLES - 5);
    chk("mode held", 8'h02, {6'h00, a_mode_o});
    cyc(30);
    chk("mode pwm", 8'h01, {6'h00, a_mode_o});
    $display("Test mode change timing done");
    same = 1'b0;
    b_en = 1'b0;
    do_reset();
    wait_code(1'b0, 8'h50);
    b_en = 1'b1;
    wait_code(1'b1, b_def);
    chk("ref at default", 8'h00, {7'h00, b_ref});
    wait_code(1'b1, 8'h28);
    cyc(2);
    chk("ref later slot", 8'h01, {7'h00, b_ref});
    $display("Test later slot done");
    track = 1'b0;
    wait_code(1'b1, b_own);
    chk("no dvs block", 8'h00, {7'h00, b_blk});
    chk("no track ref", 8'h00, {7'h00, b_ref});
    phase = 2'h1;
    b_own = 8'h30;
    cyc(40);
    chk("dual rail a", 8'h50, a_tgt);
    chk("dual rail b", 8'h00, b_tgt);
    chk("dual b mode", 8'h01, {6'h00, b_mode_o});
    $display("Test independent and dual done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
